// >>> src/gio_regs.svh
// Register offsets, field positions and reset values of the port block
`ifndef GIO_REGS_SVH
`define GIO_REGS_SVH
`define GIO_OFS_DATA0    8'h00
`define GIO_OFS_DATA1    8'h04
`define GIO_OFS_DATA2    8'h08
`define GIO_OFS_DATA4    8'h0C
`define GIO_OFS_DIR0     8'h10
`define GIO_OFS_DIR1     8'h14
`define GIO_OFS_DIR2     8'h18
`define GIO_OFS_DIR4     8'h1C
`define GIO_OFS_PULLUP   8'h20
`define GIO_OFS_OTYPE0   8'h24
`define GIO_OFS_OTYPE1   8'h28
`define GIO_OFS_ALTSEL   8'h2C
`define GIO_OFS_PIN0     8'h30
`define GIO_OFS_PIN1     8'h34
`define GIO_OFS_PIN2     8'h38
`define GIO_OFS_PIN4     8'h3C
// Pull-up enable bit groups in the pull-up option register
`define GIO_PU_P0_LSB    0
`define GIO_PU_P1_LSB    8
`define GIO_PU_P2_LSB    16
`define GIO_PU_P4_LSB    24
// Output type register zero: one bit for each of the first two 8-bit ports
`define GIO_OT0_P0_BIT   0
`define GIO_OT0_P1_BIT   1
// Output type register one: pins five and six of the 7-bit port
`define GIO_OT1_P25_BIT  5
`define GIO_OT1_P26_BIT  6
// Reset values: all inputs, no pull-ups, CMOS, port mode
`define GIO_RST_DIR      8'hFF
`define GIO_RST_DATA     8'h00
`define GIO_RST_PULLUP   32'h0000_0000
`define GIO_RST_OTYPE    8'h00
`define GIO_RST_ALTSEL   8'h00
`endif

// >>> src/gio_pkg.sv
// Types shared by the port block
package gio_pkg;
  typedef enum logic [1:0] {
    GIO_RESP_OKAY   = 2'b00,
    GIO_RESP_SLVERR = 2'b10
  } gio_resp_t;
  typedef enum logic [0:0] {
    GIO_OT_CMOS  = 1'b0,
    GIO_OT_NOPEN = 1'b1
  } gio_otype_t;
endpackage

// >>> src/gio_pin_bank.sv
// One bank of port pins: pad drive, pull-ups and input synchroniser
`timescale 1ns/100ps
module gio_pin_bank #(
  parameter int WIDTH = 8
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] out_val,
  input  wire logic [WIDTH-1:0] is_input,
  input  wire logic [WIDTH-1:0] pu_sel,
  input  wire logic [WIDTH-1:0] open_drain,
  input  wire logic [WIDTH-1:0] pad_i,
  output logic      [WIDTH-1:0] pad_o_ff,
  output logic      [WIDTH-1:0] pad_oe_n_ff,
  output logic      [WIDTH-1:0] pullup_ff,
  output logic      [WIDTH-1:0] level_ff
);
  logic [WIDTH-1:0] sync1_ff;

  // Elaboration check on the bank width
  if (WIDTH < 1 || WIDTH > 8) begin : g_bad_width
    $error("gio_pin_bank: WIDTH must be 1..8");
  end

  // Pad drive; open-drain pins only pull low, release for a high
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pad_o_ff    <= '0;
      pad_oe_n_ff <= '1;
    end else begin
      pad_o_ff    <= out_val;
      pad_oe_n_ff <= is_input | (open_drain & out_val);
    end
  end

  // Pull-up only acts on input pins
  always_ff @(posedge aclk) begin
    if (!aresetn) pullup_ff <= '0;
    else          pullup_ff <= pu_sel & is_input;
  end

  // Two-stage pin synchroniser
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_ff <= '0;
      level_ff <= '0;
    end else begin
      sync1_ff <= pad_i;
      level_ff <= sync1_ff;
    end
  end
endmodule

// >>> src/gio_port_ctrl.sv
// General-purpose port controller with AXI4-Lite register access
// Notes on behaviour
// - Every pin of the two 8-bit ports, the 7-bit port and the key port is input or output per bit.
// - An input pin gets its pull-up when its pull-up option bit is set; outputs ignore it.
// - The first two 8-bit ports choose CMOS or open-drain for the whole port in register zero.
// - Pins five and six of the 7-bit port each choose CMOS or open-drain in register one.
// - Only those eighteen pins can be switched to open-drain.
// - Pins 0, 1, 2 and 6 of the 7-bit port are selectable between port use and their alternate function.
// - The key port pin levels are also presented as key-return inputs.
`timescale 1ns/100ps
`include "gio_regs.svh"
module gio_port_ctrl
  import gio_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [7:0]  first_port_pins_i,
  output logic [7:0]       first_port_pins_o,
  output logic [7:0]       first_port_pins_oe_n,
  output logic [7:0]       first_port_pullup,
  input  wire logic [7:0]  second_port_pins_i,
  output logic [7:0]       second_port_pins_o,
  output logic [7:0]       second_port_pins_oe_n,
  output logic [7:0]       second_port_pullup,
  input  wire logic [6:0]  seven_bit_port_pins_i,
  output logic [6:0]       seven_bit_port_pins_o,
  output logic [6:0]       seven_bit_port_pins_oe_n,
  output logic [6:0]       seven_bit_port_pullup,
  input  wire logic [7:0]  key_port_pins_i,
  output logic [7:0]       key_port_pins_o,
  output logic [7:0]       key_port_pins_oe_n,
  output logic [7:0]       key_port_pullup,
  output logic [6:0]       alt_select_ff,
  input  wire logic        serial_clock_pin_out,
  input  wire logic        serial_clock_pin_oe,
  output logic             serial_clock_pin_in_ff,
  input  wire logic        serial_out_pin,
  output logic             serial_in_pin_ff,
  output logic             edge_interrupt_in_ff,
  output logic             timer_count_in_ff,
  input  wire logic        timer_out_pin,
  input  wire logic        timer_out_enable,
  output logic [7:0]       key_return_inputs_ff
);
  // Software state
  logic [7:0]  data0_ff, data1_ff, data4_ff, dir0_ff, dir1_ff, dir4_ff;
  logic [6:0]  data2_ff, dir2_ff;
  logic [31:0] pullup_option_reg_ff;
  logic [7:0]  output_type_reg_zero_ff, output_type_reg_one_ff;
  // Bus state
  logic [7:0]  aw_addr_ff;
  logic [31:0] w_data_ff, rd_word;
  logic [3:0]  w_strb_ff;
  logic        aw_held_ff, w_held_ff, do_write, wr_hit, rd_hit;
  // Synchronised pin levels and port 2 controls after the alternate mux
  logic [7:0]  lvl0, lvl1, lvl4;
  logic [6:0]  lvl2, p2_out, p2_in_mode, p2_od;
  // Write address and data latch in either order
  assign do_write = aw_held_ff && w_held_ff && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff    <= 1'b0;
      aw_addr_ff    <= 8'h00;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_ff && !s_axi_awready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_ff    <= 1'b1;
        aw_addr_ff    <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held_ff <= 1'b0;
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_ff    <= 1'b0;
      w_data_ff    <= 32'h0000_0000;
      w_strb_ff    <= 4'h0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_held_ff && !s_axi_wready;
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_ff    <= 1'b1;
        w_data_ff    <= s_axi_wdata;
        w_strb_ff    <= s_axi_wstrb;
      end else if (do_write) begin
        w_held_ff <= 1'b0;
      end
    end
  end
  // Writable window runs from DATA0 to ALTSEL, aligned words only
  assign wr_hit = (aw_addr_ff <= `GIO_OFS_ALTSEL) && (aw_addr_ff[1:0] == 2'b00);
  // Write response; pin level registers are read-only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= GIO_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? GIO_RESP_OKAY : GIO_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end
  // Control registers, byte lane 0 except the pull-up word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data0_ff <= `GIO_RST_DATA;
      data1_ff <= `GIO_RST_DATA;
      data2_ff <= 7'(`GIO_RST_DATA);
      data4_ff <= `GIO_RST_DATA;
      dir0_ff  <= `GIO_RST_DIR;
      dir1_ff  <= `GIO_RST_DIR;
      dir2_ff  <= 7'(`GIO_RST_DIR);
      dir4_ff  <= `GIO_RST_DIR;
      pullup_option_reg_ff    <= `GIO_RST_PULLUP;
      output_type_reg_zero_ff <= `GIO_RST_OTYPE;
      output_type_reg_one_ff  <= `GIO_RST_OTYPE;
      alt_select_ff           <= 7'(`GIO_RST_ALTSEL);
    end else if (do_write) begin
      if (w_strb_ff[0]) begin
        unique case (aw_addr_ff)
          `GIO_OFS_DATA0:  data0_ff <= w_data_ff[7:0];
          `GIO_OFS_DATA1:  data1_ff <= w_data_ff[7:0];
          `GIO_OFS_DATA2:  data2_ff <= w_data_ff[6:0];
          `GIO_OFS_DATA4:  data4_ff <= w_data_ff[7:0];
          `GIO_OFS_DIR0:   dir0_ff  <= w_data_ff[7:0];
          `GIO_OFS_DIR1:   dir1_ff  <= w_data_ff[7:0];
          `GIO_OFS_DIR2:   dir2_ff  <= w_data_ff[6:0];
          `GIO_OFS_DIR4:   dir4_ff  <= w_data_ff[7:0];
          // Only the implemented open-drain bits are kept
          `GIO_OFS_OTYPE0: output_type_reg_zero_ff <= w_data_ff[7:0] & 8'h03;
          `GIO_OFS_OTYPE1: output_type_reg_one_ff <= w_data_ff[7:0] & 8'h60;
          `GIO_OFS_ALTSEL: alt_select_ff <= w_data_ff[6:0];
          default: ;
        endcase
      end
      if (aw_addr_ff == `GIO_OFS_PULLUP) begin
        for (int b = 0; b < 4; b++) begin
          if (w_strb_ff[b]) pullup_option_reg_ff[b*8 +: 8] <= w_data_ff[b*8 +: 8];
        end
        pullup_option_reg_ff[23] <= 1'b0; // No eighth pin on the 7-bit port
      end
    end
  end
  // Read mux
  always_comb begin
    rd_hit  = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (s_axi_araddr)
      `GIO_OFS_DATA0:  rd_word[7:0] = data0_ff;
      `GIO_OFS_DATA1:  rd_word[7:0] = data1_ff;
      `GIO_OFS_DATA2:  rd_word[6:0] = data2_ff;
      `GIO_OFS_DATA4:  rd_word[7:0] = data4_ff;
      `GIO_OFS_DIR0:   rd_word[7:0] = dir0_ff;
      `GIO_OFS_DIR1:   rd_word[7:0] = dir1_ff;
      `GIO_OFS_DIR2:   rd_word[6:0] = dir2_ff;
      `GIO_OFS_DIR4:   rd_word[7:0] = dir4_ff;
      `GIO_OFS_PULLUP: rd_word      = pullup_option_reg_ff;
      `GIO_OFS_OTYPE0: rd_word[7:0] = output_type_reg_zero_ff;
      `GIO_OFS_OTYPE1: rd_word[7:0] = output_type_reg_one_ff;
      `GIO_OFS_ALTSEL: rd_word[6:0] = alt_select_ff;
      `GIO_OFS_PIN0:   rd_word[7:0] = lvl0;
      `GIO_OFS_PIN1:   rd_word[7:0] = lvl1;
      `GIO_OFS_PIN2:   rd_word[6:0] = lvl2;
      `GIO_OFS_PIN4:   rd_word[7:0] = lvl4;
      default:         rd_hit       = 1'b0;
    endcase
  end
  // Read channel: one cycle arready pulse, data next cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= GIO_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_word;
        s_axi_rresp   <= rd_hit ? GIO_RESP_OKAY : GIO_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  // Port 2 alternate function mux: pin0 clock, pin1 data out, pin6 timer out
  always_comb begin
    p2_out     = data2_ff;
    p2_in_mode = dir2_ff;
    p2_od      = {output_type_reg_one_ff[`GIO_OT1_P26_BIT],
                  output_type_reg_one_ff[`GIO_OT1_P25_BIT], 5'b0_0000};
    if (alt_select_ff[0]) begin
      p2_out[0]     = serial_clock_pin_out;
      p2_in_mode[0] = !serial_clock_pin_oe;
    end
    if (alt_select_ff[1]) begin
      p2_out[1]     = serial_out_pin;
      p2_in_mode[1] = 1'b0;
    end
    if (alt_select_ff[2]) p2_in_mode[2] = 1'b1; // Serial data input
    if (alt_select_ff[6]) begin
      p2_out[6]     = timer_out_pin;
      p2_in_mode[6] = !timer_out_enable;
    end
  end
  // Alternate-function inputs, gated by selection; key-return inputs always follow the key port levels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_clock_pin_in_ff <= 1'b0;
      serial_in_pin_ff       <= 1'b0;
      edge_interrupt_in_ff   <= 1'b0;
      timer_count_in_ff      <= 1'b0;
      key_return_inputs_ff   <= 8'h00;
    end else begin
      serial_clock_pin_in_ff <= alt_select_ff[0] & lvl2[0];
      serial_in_pin_ff       <= alt_select_ff[2] & lvl2[2];
      edge_interrupt_in_ff   <= alt_select_ff[6] & lvl2[6];
      timer_count_in_ff      <= alt_select_ff[6] & lvl2[6];
      key_return_inputs_ff   <= lvl4;
    end
  end
  // Pin banks; the key port is always CMOS
  gio_pin_bank #(.WIDTH(8)) u_bank0 (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .out_val     (data0_ff),
    .is_input    (dir0_ff),
    .pu_sel      (pullup_option_reg_ff[`GIO_PU_P0_LSB +: 8]),
    .open_drain  ({8{output_type_reg_zero_ff[`GIO_OT0_P0_BIT]}}),
    .pad_i       (first_port_pins_i),
    .pad_o_ff    (first_port_pins_o),
    .pad_oe_n_ff (first_port_pins_oe_n),
    .pullup_ff   (first_port_pullup),
    .level_ff    (lvl0)
  );
  gio_pin_bank #(.WIDTH(8)) u_bank1 (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .out_val     (data1_ff),
    .is_input    (dir1_ff),
    .pu_sel      (pullup_option_reg_ff[`GIO_PU_P1_LSB +: 8]),
    .open_drain  ({8{output_type_reg_zero_ff[`GIO_OT0_P1_BIT]}}),
    .pad_i       (second_port_pins_i),
    .pad_o_ff    (second_port_pins_o),
    .pad_oe_n_ff (second_port_pins_oe_n),
    .pullup_ff   (second_port_pullup),
    .level_ff    (lvl1)
  );
  gio_pin_bank #(.WIDTH(7)) u_bank2 (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .out_val     (p2_out),
    .is_input    (p2_in_mode),
    .pu_sel      (pullup_option_reg_ff[`GIO_PU_P2_LSB +: 7]),
    .open_drain  (p2_od),
    .pad_i       (seven_bit_port_pins_i),
    .pad_o_ff    (seven_bit_port_pins_o),
    .pad_oe_n_ff (seven_bit_port_pins_oe_n),
    .pullup_ff   (seven_bit_port_pullup),
    .level_ff    (lvl2)
  );
  gio_pin_bank #(.WIDTH(8)) u_bank4 (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .out_val     (data4_ff),
    .is_input    (dir4_ff),
    .pu_sel      (pullup_option_reg_ff[`GIO_PU_P4_LSB +: 8]),
    .open_drain  (8'h00),
    .pad_i       (key_port_pins_i),
    .pad_o_ff    (key_port_pins_o),
    .pad_oe_n_ff (key_port_pins_oe_n),
    .pullup_ff   (key_port_pullup),
    .level_ff    (lvl4)
  );
endmodule

// >>> testbench/gio_port_ctrl_props.sv
// Concurrent checks on the port controller ports
`timescale 1ns/100ps
module gio_port_ctrl_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  first_port_pins_oe_n,
  input wire logic [7:0]  first_port_pullup,
  input wire logic [7:0]  key_port_pins_oe_n,
  input wire logic [7:0]  key_port_pullup,
  input wire logic [6:0]  seven_bit_port_pins_i,
  input wire logic [6:0]  seven_bit_port_pins_o,
  input wire logic [7:0]  key_port_pins_i,
  input wire logic [7:0]  key_return_inputs_ff,
  input wire logic [6:0]  alt_select_ff,
  input wire logic        serial_out_pin,
  input wire logic        serial_in_pin_ff
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [2:0] up_cnt_ff;
  // Cycles since reset release, saturating; hides synchroniser fill
  always_ff @(posedge aclk) begin
    if (!aresetn) up_cnt_ff <= 3'h0;
    else if (up_cnt_ff != 3'h7) up_cnt_ff <= up_cnt_ff + 3'h1;
  end
  // Pin-side behaviour
  chk_reset_state: assert property ($rose(aresetn) |-> first_port_pins_oe_n == 8'hFF
    && key_port_pullup == 8'h00 && alt_select_ff == 7'h00) else $error("bad reset state");
  chk_pullup_input: assert property ((first_port_pullup & ~first_port_pins_oe_n) == 8'h00
    && (key_port_pullup & ~key_port_pins_oe_n) == 8'h00) else $error("pull-up on output");
  chk_key_return: assert property (up_cnt_ff > 3'h3 |->
    key_return_inputs_ff == $past(key_port_pins_i, 3)) else $error("key return level wrong");
  chk_serial_in_on: assert property ((alt_select_ff[2] && seven_bit_port_pins_i[2])[*4]
    |-> serial_in_pin_ff) else $error("serial input not passed");
  chk_serial_in_off: assert property ((!alt_select_ff[2])[*2] |-> !serial_in_pin_ff)
    else $error("serial input leaks");
  chk_serial_out: assert property ((alt_select_ff[1] && serial_out_pin)[*3]
    |-> seven_bit_port_pins_o[1]) else $error("serial output not driven");
  // Register bus handshakes
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_read_cause: assert property (s_axi_rvalid |->
    $past(s_axi_arvalid && s_axi_arready) || $past(s_axi_rvalid)) else $error("stray read data");
  chk_write_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
  cover property (alt_select_ff[2] && serial_in_pin_ff);
endmodule

// >>> testbench/gio_pad_model.sv
// Board-side pad model: device drive, board drive, pull-up or a wandering level
`timescale 1ns/100ps
module gio_pad_model #(
  parameter int W = 8
) (
  input  wire logic [0:0]   aclk,
  input  wire logic [W-1:0] pin_o,
  input  wire logic [W-1:0] pin_oe_n,
  input  wire logic [W-1:0] pu_on,
  input  wire logic         ext_en,
  input  wire logic [W-1:0] ext_val,
  output logic      [W-1:0] pin_i
);
  logic [W-1:0] float_ff = '0;
  // Undriven pins without pull-up change every cycle
  always_ff @(posedge aclk) float_ff <= ~float_ff;
  // Device drive wins, then board drive, then pull-up
  always_comb begin
    for (int b = 0; b < W; b++) begin
      if (!pin_oe_n[b]) pin_i[b] = pin_o[b];
      else if (ext_en) pin_i[b] = ext_val[b];
      else if (pu_on[b]) pin_i[b] = 1'b1;
      else pin_i[b] = float_ff[b];
    end
  end
endmodule

// >>> testbench/tb_gio_port_ctrl.sv
// Self-checking bench for the port controller
`timescale 1ns/100ps
`include "gio_regs.svh"
module tb_gio_port_ctrl;
  import gio_pkg::*;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [7:0]  first_port_pins_i, first_port_pins_o, first_port_pins_oe_n, first_port_pullup;
  logic [7:0]  second_port_pins_i, second_port_pins_o, second_port_pins_oe_n, second_port_pullup;
  logic [6:0]  seven_bit_port_pins_i, seven_bit_port_pins_o, seven_bit_port_pins_oe_n;
  logic [6:0]  seven_bit_port_pullup, alt_select_ff;
  logic [7:0]  key_port_pins_i, key_port_pins_o, key_port_pins_oe_n, key_port_pullup;
  logic        serial_clock_pin_out = 1'b0, serial_clock_pin_oe = 1'b0, serial_out_pin = 1'b1;
  logic        timer_out_pin = 1'b0, timer_out_enable = 1'b0;
  logic        serial_clock_pin_in_ff, serial_in_pin_ff, edge_interrupt_in_ff, timer_count_in_ff;
  logic [7:0]  key_return_inputs_ff;
  logic [7:0]  poe [4], ppu [4];
  logic [7:0]  ext_val [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
  logic [3:0]  ext_en = 4'h0;
  int          errors = 0;
  int          compares = 0;
  // Per-port views of enables and pull-ups
  assign poe = '{first_port_pins_oe_n, second_port_pins_oe_n, {1'b0, seven_bit_port_pins_oe_n},
                 key_port_pins_oe_n};
  assign ppu = '{first_port_pullup, second_port_pullup, {1'b0, seven_bit_port_pullup},
                 key_port_pullup};
  gio_port_ctrl i_gio_port_ctrl (.*);
  gio_pad_model #(.W(8)) i_gio_pad_model_p0 (.aclk(aclk), .pin_o(first_port_pins_o),
    .pin_oe_n(first_port_pins_oe_n), .pu_on(first_port_pullup), .ext_en(ext_en[0]),
    .ext_val(ext_val[0]), .pin_i(first_port_pins_i));
  gio_pad_model #(.W(8)) i_gio_pad_model_p1 (.aclk(aclk), .pin_o(second_port_pins_o),
    .pin_oe_n(second_port_pins_oe_n), .pu_on(second_port_pullup), .ext_en(ext_en[1]),
    .ext_val(ext_val[1]), .pin_i(second_port_pins_i));
  gio_pad_model #(.W(7)) i_gio_pad_model_p2 (.aclk(aclk), .pin_o(seven_bit_port_pins_o),
    .pin_oe_n(seven_bit_port_pins_oe_n), .pu_on(seven_bit_port_pullup), .ext_en(ext_en[2]),
    .ext_val(ext_val[2][6:0]), .pin_i(seven_bit_port_pins_i));
  gio_pad_model #(.W(8)) i_gio_pad_model_p4 (.aclk(aclk), .pin_o(key_port_pins_o),
    .pin_oe_n(key_port_pins_oe_n), .pu_on(key_port_pullup), .ext_en(ext_en[3]),
    .ext_val(ext_val[3]), .pin_i(key_port_pins_i));
  // Clock
  initial begin
    forever #5 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rresp, er);
    chk(s_axi_rdata, ed);
  endtask
  task automatic settle();
    repeat (5) @(posedge aclk);
  endtask
  task automatic reset_test();
    @(posedge aclk);
    for (int k = 0; k < 4; k++) begin
      chk(poe[k], k == 2 ? 8'h7F : 8'hFF);
      chk(ppu[k], 8'h00);
    end
    chk(alt_select_ff, 7'h00);
    rd(`GIO_OFS_DIR0, 32'hFF, GIO_RESP_OKAY);
    rd(`GIO_OFS_PULLUP, 32'h0, GIO_RESP_OKAY);
    rd(`GIO_OFS_OTYPE0, 32'h0, GIO_RESP_OKAY);
    rd(8'h40, 32'h0, GIO_RESP_SLVERR);
    $display("test reset done");
  endtask
  // Mixed directions with board drive on inputs: outputs A5, inputs 3C
  task automatic port_test();
    logic [7:0] m;
    ext_en <= 4'hF;
    for (int k = 0; k < 4; k++) ext_val[k] <= 8'h3C;
    for (int k = 0; k < 4; k++) begin
      m = k == 2 ? 8'h7F : 8'hFF;
      wr(`GIO_OFS_DATA0 + 8'(4 * k), 32'hA5, GIO_RESP_OKAY);
      wr(`GIO_OFS_DIR0 + 8'(4 * k), 32'h5A, GIO_RESP_OKAY);
      settle();
      chk(poe[k], 8'h5A & m);
      rd(`GIO_OFS_PIN0 + 8'(4 * k), 32'((8'hA5 & ~8'h5A | 8'h3C & 8'h5A) & m), GIO_RESP_OKAY);
      if (k == 3) chk(key_return_inputs_ff, 8'hA5 & ~8'h5A | 8'h3C & 8'h5A);
    end
    $display("test direction done");
  endtask
  task automatic pull_test();
    logic [7:0] m;
    ext_en <= 4'h0;
    wr(`GIO_OFS_PULLUP, 32'hFFFF_FFFF, GIO_RESP_OKAY);
    settle();
    for (int k = 0; k < 4; k++) begin
      m = k == 2 ? 8'h7F : 8'hFF;
      chk(ppu[k], 8'h5A & m);
      rd(`GIO_OFS_PIN0 + 8'(4 * k), 32'(m), GIO_RESP_OKAY);
    end
    $display("test pull-up done");
  endtask
  // All outputs high with every open-drain bit set, then all low
  task automatic drive_test();
    logic [7:0] od_exp [4] = '{8'hFF, 8'hFF, 8'h60, 8'h00};
    wr(`GIO_OFS_OTYPE0, 32'hFF, GIO_RESP_OKAY);
    wr(`GIO_OFS_OTYPE1, 32'hFF, GIO_RESP_OKAY);
    for (int k = 0; k < 4; k++) begin
      wr(`GIO_OFS_DATA0 + 8'(4 * k), 32'hFF, GIO_RESP_OKAY);
      wr(`GIO_OFS_DIR0 + 8'(4 * k), 32'h00, GIO_RESP_OKAY);
    end
    settle();
    for (int k = 0; k < 4; k++) begin
      chk(poe[k], od_exp[k]);
      chk(ppu[k], 8'h00);
      wr(`GIO_OFS_DATA0 + 8'(4 * k), 32'h00, GIO_RESP_OKAY);
    end
    settle();
    for (int k = 0; k < 4; k++) chk(poe[k], 8'h00);
    rd(`GIO_OFS_OTYPE0, 32'h03, GIO_RESP_OKAY);
    rd(`GIO_OFS_OTYPE1, 32'h60, GIO_RESP_OKAY);
    $display("test output type done");
  endtask
  task automatic alt_test();
    ext_en <= 4'h4;
    ext_val[2] <= 8'h45;
    wr(`GIO_OFS_DIR2, 32'h7F, GIO_RESP_OKAY);
    wr(`GIO_OFS_ALTSEL, 32'h47, GIO_RESP_OKAY);
    settle();
    chk(alt_select_ff, 7'h47);
    chk(serial_in_pin_ff, 1'b1);
    chk(serial_clock_pin_in_ff, 1'b1);
    chk({edge_interrupt_in_ff, timer_count_in_ff}, 2'b11);
    chk(poe[2], 8'h7D);
    rd(`GIO_OFS_PIN2, 32'h47, GIO_RESP_OKAY);
    wr(`GIO_OFS_ALTSEL, 32'h00, GIO_RESP_OKAY);
    settle();
    chk(serial_in_pin_ff, 1'b0);
    chk({serial_clock_pin_in_ff, edge_interrupt_in_ff, timer_count_in_ff}, 3'b000);
    wr(`GIO_OFS_PIN0, 32'hFF, GIO_RESP_SLVERR);
    wr(8'h44, 32'hFF, GIO_RESP_SLVERR);
    rd(`GIO_OFS_DATA0, 32'h00, GIO_RESP_OKAY);
    $display("test alternate done");
  endtask
  task automatic results();
    $display("counts: %0d compares, %0d errors", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Main sequence with a second reset in mid-run
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    reset_test();
    port_test();
    pull_test();
    drive_test();
    alt_test();
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    reset_test();
    results();
  end
  // Watchdog against a hung handshake
  initial begin
    repeat (5000) @(posedge aclk);
    errors++;
    results();
  end
endmodule
bind gio_port_ctrl gio_port_ctrl_props i_gio_port_ctrl_props (.*);
